/* File: hdl/bls_consts.svh */
// register offsets, field positions, reset values and timing constants of the backlight sequencer
`ifndef BLS_CONSTS_SVH
`define BLS_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define BLS_OFS_MODE     8'h01
`define BLS_OFS_FAULT    8'h02
`define BLS_OFS_MASK     8'h03
`define BLS_OFS_CFG      8'h04
`define BLS_OFS_GROUP    8'h05
`define BLS_OFS_OFFD     8'h06
`define BLS_OFS_DIMD     8'h07
`define BLS_OFS_SINK_EN  8'h10
`define BLS_OFS_BOFF_HI  8'h11
`define BLS_OFS_BOFF_LO  8'h12

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BLS_MODE_ACT     0
`define BLS_MODE_DIM     4
`define BLS_MODE_BL      5
`define BLS_FLAG_OVER    0
`define BLS_FLAG_HOT     1
`define BLS_FLAG_SHORT   2
`define BLS_CFG_BYPASS   2
`define BLS_BON_LSB      6

// ----------------------------------------------------------------
// reset value, full and dim level codes
// ----------------------------------------------------------------
`define BLS_RST_BYTE     8'h00
`define BLS_MAX_CODE     7'h7f
`define BLS_DIM_CODE     7'h20

// ----------------------------------------------------------------
// timing: clock period, short blanking, blink tick, fade step
// ----------------------------------------------------------------
`define BLS_CLK_NS       4
`define BLS_BLANK_US     4000
`define BLS_SUBTICK_MS   200
`define BLS_FADE_STEP_US 787
`define BLS_SEC_SUBTICKS 3'h4

`endif

/* File: hdl/bls_pkg.sv */
// types shared by the backlight sequencer
package bls_pkg;

   typedef enum logic [1:0] {BLS_STANDBY, BLS_ACTIVE, BLS_SHORTED} bls_mode_e;

   // register access request from the serial bus back end
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } bls_reg_req_s;

   // analog fault detector levels
   typedef struct packed {
      logic shorted;
      logic overvolt;
      logic hot;
   } bls_fault_s;

   // complete state of the sequencer
   typedef struct packed {
      bls_mode_e mode;
      logic act;
      logic bl;
      logic dim;
      logic [2:0] flags;
      logic [2:0] mask;
      logic [7:0] cfg;
      logic [6:0] group_sel;
      logic [6:0] sink_en;
      logic [6:0] offd;
      logic [6:0] dimd;
      logic [7:0] boff_hi;
      logic [7:0] boff_lo;
      logic [31:0] div;
      logic [2:0] sec_div;
      logic [6:0] dim_cnt;
      logic [6:0] off_cnt;
      logic [31:0] blank;
      logic [31:0] fade_div;
      logic [6:0] level;
      logic [6:0] phase;
      logic [6:0][3:0] bcnt;
      bls_fault_s fs1;
      bls_fault_s fs2;
      logic over_d;
      logic [7:0] rd_data;
      logic irq_n;
      logic cp_en;
      logic low_cur;
      logic [6:0] sink_on;
   } bls_state_s;

endpackage

/* File: hdl/bls_sequencer.sv */
// backlight on/dim/off sequencer with blink sinks, fault handling and interrupt output
`timescale 1ns/1ps
`include "bls_consts.svh"

// Contract
// R1: backlight_on bit turns backlight on/off when active
// R2: dim_select picks dim level, clear restores max
// R3: dim delay 1-127 s, starts at enable
// R4: dim expiry sets dim_select itself
// R5: host dim clear restarts dim timer
// R6: off delay 1-127 s, concurrent with dim
// R7: off expiry clears backlight_on
// R8: host clear of backlight_on is immediate
// R9: bypass restores pre-fade level on re-enable
// R10: bypass jumps to target during fade-in
// R11: no bypass: resume fade from current level
// R12: sinks assignable to group or independent
// R13: shared blink on-time, four durations
// R14: per-sink off-time; nonzero enables blinking
// R15: enable clear: on-phase off, off-phase stays
// R16: host programs timers before enabling outputs
// R17: short ignored 4 ms, then latch and park
// R18: active_request write restarts after short
// R19: overvoltage stops pump only, flag each time
// R20: thermal trip: standby, flag, re-raise while hot
// R21: irq_out_n asserts for masked-in flags only
// R22: flags clear only by writing one
// R23: active_request bit enters active mode
// R24: standby disables all, soft start on exit
// R25: common divided tick for all timers; the short blanking and the fade step count sys_clk cycles instead
module bls_sequencer #(
   parameter int unsigned BLANK_CYC = (`BLS_BLANK_US * 1000 + `BLS_CLK_NS - 1) / `BLS_CLK_NS,
   parameter int unsigned SUBTICK_CYC = `BLS_SUBTICK_MS * 1000000 / `BLS_CLK_NS,
   parameter int unsigned FADE_CYC = `BLS_FADE_STEP_US * 1000 / `BLS_CLK_NS,
   parameter logic [6:0] MAX_CODE = `BLS_MAX_CODE,
   parameter logic [6:0] DIM_CODE = `BLS_DIM_CODE
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // register access
   input wire bls_pkg::bls_reg_req_s reg_req,
   output logic [7:0] rd_data,
   // fault detectors
   input wire bls_pkg::bls_fault_s fault_in,
   // drive outputs
   output logic [6:0] backlight_level,
   output logic [6:0] sink_on,
   output logic charge_pump_en,
   output logic low_current,
   output logic irq_out_n
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   bls_pkg::bls_state_s st_reg;
   bls_pkg::bls_state_s st_next;
   logic sub_tick;
   logic sec_tick;
   logic run;
   logic [6:0] target;

   // blink on-time in 0.2 s ticks
   function automatic logic [3:0] on_ticks(input logic [1:0] sel);
      case (sel)
         2'h0: on_ticks = 4'h1;
         2'h1: on_ticks = 4'h3;
         2'h2: on_ticks = 4'h4;
         default: on_ticks = 4'h6;
      endcase
   endfunction

   // blink off-time in 0.2 s ticks, zero means no blinking
   function automatic logic [3:0] off_ticks(input logic [1:0] sel);
      case (sel)
         2'h0: off_ticks = 4'h0;
         2'h1: off_ticks = 4'h3;
         2'h2: off_ticks = 4'h6;
         default: off_ticks = 4'h9;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      logic wr_mode;
      logic [1:0] osel;
      logic [3:0] lim;
      logic en_i;
      wr_mode = 1'b0;
      osel = 2'h0;
      lim = 4'h0;
      en_i = 1'b0;
      st_next = st_reg;

      // one divider feeds blink, dim and off timers (see R25)
      sub_tick = st_reg.div == 32'(SUBTICK_CYC - 1);
      sec_tick = sub_tick && (st_reg.sec_div == `BLS_SEC_SUBTICKS);
      st_next.div = sub_tick ? 32'h0000_0000 : st_reg.div + 32'h0000_0001;
      if (sub_tick) begin
         st_next.sec_div = sec_tick ? 3'h0 : st_reg.sec_div + 3'h1;
      end

      // detector levels come from outside: two flops before use
      st_next.fs1 = fault_in;
      st_next.fs2 = st_reg.fs1;
      st_next.over_d = st_reg.fs2.overvolt;

      // register writes
      if (reg_req.wr) begin
         case (reg_req.addr)
            `BLS_OFS_MODE: begin
               wr_mode = 1'b1;
               st_next.act = reg_req.wdata[`BLS_MODE_ACT]; // see R23
               st_next.bl = reg_req.wdata[`BLS_MODE_BL]; // see R1 see R8
               st_next.dim = reg_req.wdata[`BLS_MODE_DIM]; // see R2
            end
            `BLS_OFS_FAULT: st_next.flags = st_reg.flags & ~reg_req.wdata[2:0]; // see R22
            `BLS_OFS_MASK: st_next.mask = reg_req.wdata[2:0];
            `BLS_OFS_CFG: st_next.cfg = reg_req.wdata;
            `BLS_OFS_GROUP: st_next.group_sel = reg_req.wdata[6:0]; // see R12
            `BLS_OFS_OFFD: st_next.offd = reg_req.wdata[6:0]; // see R6
            `BLS_OFS_DIMD: st_next.dimd = reg_req.wdata[6:0]; // see R3
            `BLS_OFS_SINK_EN: st_next.sink_en = reg_req.wdata[6:0];
            `BLS_OFS_BOFF_HI: st_next.boff_hi = reg_req.wdata;
            `BLS_OFS_BOFF_LO: st_next.boff_lo = reg_req.wdata;
            default: ;
         endcase
      end

      // operating mode; each entry to active reloads the short blanking
      case (st_reg.mode)
         bls_pkg::BLS_STANDBY: begin
            if (wr_mode && st_next.act) begin
               st_next.mode = bls_pkg::BLS_ACTIVE; // see R23 see R24
               st_next.blank = 32'(BLANK_CYC);
            end
         end
         bls_pkg::BLS_ACTIVE: begin
            if (!st_next.act) begin
               st_next.mode = bls_pkg::BLS_STANDBY;
            end else if (st_reg.blank != 32'h0000_0000) begin
               st_next.blank = st_reg.blank - 32'h0000_0001; // see R17
            end else if (st_reg.fs2.shorted) begin
               st_next.mode = bls_pkg::BLS_SHORTED; // see R17
               st_next.flags[`BLS_FLAG_SHORT] = 1'b1;
            end
         end
         bls_pkg::BLS_SHORTED: begin
            if (wr_mode && st_next.act) begin
               st_next.mode = bls_pkg::BLS_ACTIVE; // see R18
               st_next.blank = 32'(BLANK_CYC);
            end else if (wr_mode) begin
               st_next.mode = bls_pkg::BLS_STANDBY;
            end
         end
         default: st_next.mode = bls_pkg::BLS_STANDBY;
      endcase

      // hot die forces standby and keeps its flag set while hot
      if (st_reg.fs2.hot) begin
         st_next.act = 1'b0; // see R20
         st_next.mode = bls_pkg::BLS_STANDBY;
         st_next.flags[`BLS_FLAG_HOT] = 1'b1;
      end

      // every overvoltage rising edge sets its flag; set beats a clear
      if (st_reg.fs2.overvolt && !st_reg.over_d) begin
         st_next.flags[`BLS_FLAG_OVER] = 1'b1; // see R19
      end

      run = st_next.mode == bls_pkg::BLS_ACTIVE;

      // dim timer reloads while idle, so a host dim clear restarts it
      if (!(st_reg.mode == bls_pkg::BLS_ACTIVE && st_reg.bl && !st_reg.dim)) begin
         st_next.dim_cnt = st_reg.dimd; // see R3 see R5
      end else if (sec_tick) begin
         if (st_reg.dim_cnt == 7'h01) begin
            st_next.dim = 1'b1; // see R4
         end else if (st_reg.dim_cnt != 7'h00) begin
            st_next.dim_cnt = st_reg.dim_cnt - 7'h01;
         end
      end

      // off timer runs alongside the dim timer
      if (!(st_reg.mode == bls_pkg::BLS_ACTIVE && st_reg.bl)) begin
         st_next.off_cnt = st_reg.offd; // see R6
      end else if (sec_tick) begin
         if (st_reg.off_cnt == 7'h01) begin
            st_next.bl = 1'b0; // see R7
         end else if (st_reg.off_cnt != 7'h00) begin
            st_next.off_cnt = st_reg.off_cnt - 7'h01;
         end
      end

      // fade engine: one code per step; bypass jumps on re-enable
      target = (run && st_next.bl) ? (st_next.dim ? DIM_CODE : MAX_CODE) : 7'h00; // see R2
      st_next.fade_div = (st_reg.fade_div == 32'(FADE_CYC - 1)) ? 32'h0000_0000 :
         st_reg.fade_div + 32'h0000_0001;
      if (!run) begin
         st_next.level = 7'h00; // see R24
      end else if (wr_mode && st_next.bl && st_reg.cfg[`BLS_CFG_BYPASS]) begin
         st_next.level = target; // see R9 see R10
      end else if (!st_next.bl) begin
         st_next.level = 7'h00; // see R8
      end else if (st_reg.fade_div == 32'(FADE_CYC - 1)) begin
         // resumes from wherever it stands, never restarting at zero
         if (st_reg.level < target) begin
            st_next.level = st_reg.level + 7'h01; // see R11
         end else if (st_reg.level > target) begin
            st_next.level = st_reg.level - 7'h01;
         end
      end

      // independent sinks: shared on-time, per-sink off-time
      for (int i = 0; i < 7; i++) begin
         osel = (i < 4) ? st_reg.boff_lo[2 * i +: 2] : st_reg.boff_hi[2 * (i - 4) +: 2];
         en_i = run && st_next.group_sel[i] && st_next.sink_en[i]; // see R12
         lim = st_reg.phase[i] ? on_ticks(st_reg.boff_hi[`BLS_BON_LSB +: 2]) : off_ticks(osel); // see R13
         if (!en_i) begin
            // clearing mid on-phase ends the pulse; mid off-phase stays dark
            st_next.phase[i] = 1'b1; // see R15
            st_next.bcnt[i] = 4'h0;
         end else if (off_ticks(osel) == 4'h0) begin
            st_next.phase[i] = 1'b1; // see R14
            st_next.bcnt[i] = 4'h0;
         end else if (sub_tick) begin
            if (st_reg.bcnt[i] + 4'h1 >= lim) begin
               st_next.phase[i] = ~st_reg.phase[i]; // see R14
               st_next.bcnt[i] = 4'h0;
            end else begin
               st_next.bcnt[i] = st_reg.bcnt[i] + 4'h1;
            end
         end
         st_next.sink_on[i] = en_i && st_next.phase[i];
      end

      // overvoltage stops only the pump; other outputs carry on
      st_next.cp_en = run && !st_reg.fs2.overvolt; // see R19
      st_next.irq_n = ~|(st_next.flags & st_next.mask); // see R21
      // park indication kept in its own flop so the pin needs no decoding
      st_next.low_cur = st_next.mode == bls_pkg::BLS_SHORTED; // see R17

      // read data, one cycle after the read strobe
      if (reg_req.rd) begin
         case (reg_req.addr)
            `BLS_OFS_MODE: st_next.rd_data = {2'h0, st_reg.bl, st_reg.dim, 3'h0, st_reg.act};
            `BLS_OFS_FAULT: st_next.rd_data = {5'h00, st_reg.flags};
            `BLS_OFS_MASK: st_next.rd_data = {5'h00, st_reg.mask};
            `BLS_OFS_CFG: st_next.rd_data = st_reg.cfg;
            `BLS_OFS_GROUP: st_next.rd_data = {1'b0, st_reg.group_sel};
            `BLS_OFS_OFFD: st_next.rd_data = {1'b0, st_reg.offd};
            `BLS_OFS_DIMD: st_next.rd_data = {1'b0, st_reg.dimd};
            `BLS_OFS_SINK_EN: st_next.rd_data = {1'b0, st_reg.sink_en};
            `BLS_OFS_BOFF_HI: st_next.rd_data = st_reg.boff_hi;
            `BLS_OFS_BOFF_LO: st_next.rd_data = st_reg.boff_lo;
            default: st_next.rd_data = `BLS_RST_BYTE;
         endcase
      end
   end

   // state register with synchronous reset
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         st_reg <= '0;
         st_reg.irq_n <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // outputs straight from the state flops
   assign rd_data = st_reg.rd_data;
   assign backlight_level = st_reg.level;
   assign sink_on = st_reg.sink_on;
   assign charge_pump_en = st_reg.cp_en;
   assign low_current = st_reg.low_cur;
   assign irq_out_n = st_reg.irq_n;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (srst);

   a_flag_write_zero: // see R22
   assert property ((reg_req.wr && reg_req.addr == `BLS_OFS_FAULT && !reg_req.wdata[`BLS_FLAG_HOT]
      && st_reg.flags[`BLS_FLAG_HOT]) |=> st_reg.flags[`BLS_FLAG_HOT])
   else $error("thermal flag lost on zero write");

   a_flag_write_one: // see R22
   assert property ((reg_req.wr && reg_req.addr == `BLS_OFS_FAULT && reg_req.wdata[`BLS_FLAG_HOT]
      && !st_reg.fs2.hot) |=> !st_reg.flags[`BLS_FLAG_HOT])
   else $error("thermal flag not cleared by one");

   a_irq_masked_out: // see R21
   assert property ((st_reg.flags & st_reg.mask) == 3'h0 |-> irq_out_n)
   else $error("interrupt asserted with no enabled flag");

   a_off_timer_expiry: // see R7
   assert property ((sec_tick && st_reg.mode == bls_pkg::BLS_ACTIVE && st_reg.bl && st_reg.off_cnt == 7'h01
      && !st_reg.fs2.hot) |=> !st_reg.bl && backlight_level == 7'h00)
   else $error("off timer expiry did not clear backlight");

   a_dim_timer_expiry: // see R4
   assert property ((sec_tick && st_reg.mode == bls_pkg::BLS_ACTIVE && st_reg.bl && !st_reg.dim
      && st_reg.dim_cnt == 7'h01) |=> st_reg.dim)
   else $error("dim timer expiry did not set dim");

   a_standby_dark: // see R24
   assert property (st_reg.mode != bls_pkg::BLS_ACTIVE |-> sink_on == 7'h00 && !charge_pump_en)
   else $error("outputs live outside active mode");

   a_short_blanking: // see R17
   assert property ((st_reg.mode == bls_pkg::BLS_ACTIVE && st_reg.blank != 32'h0000_0000)
      |=> st_reg.mode != bls_pkg::BLS_SHORTED)
   else $error("short honoured during blanking");

   a_thermal_standby: // see R20
   assert property (st_reg.fs2.hot |=> !st_reg.act && st_reg.flags[`BLS_FLAG_HOT]
      && st_reg.mode == bls_pkg::BLS_STANDBY)
   else $error("thermal trip not handled");

   a_over_pump_off: // see R19
   assert property ($rose(st_reg.fs2.overvolt) |=> !charge_pump_en && st_reg.flags[`BLS_FLAG_OVER])
   else $error("overvoltage did not stop pump or set flag");

   a_bypass_jump: // see R10
   assert property ((reg_req.wr && reg_req.addr == `BLS_OFS_MODE && reg_req.wdata[`BLS_MODE_BL]
      && !reg_req.wdata[`BLS_MODE_DIM] && reg_req.wdata[`BLS_MODE_ACT] && st_reg.cfg[`BLS_CFG_BYPASS]
      && st_reg.mode == bls_pkg::BLS_ACTIVE && !st_reg.fs2.hot && !st_reg.fs2.shorted && !sec_tick)
      |=> backlight_level == MAX_CODE)
   else $error("fade bypass did not jump to target");

   a_host_off_now: // see R8
   assert property ((reg_req.wr && reg_req.addr == `BLS_OFS_MODE && !reg_req.wdata[`BLS_MODE_BL])
      |=> backlight_level == 7'h00)
   else $error("backlight not off after host clear");

   a_irq_masked_in: // see R21
   assert property ((st_reg.flags & st_reg.mask) != 3'h0 |-> !irq_out_n)
   else $error("interrupt missing for enabled flag");

   a_group_sink_dark: // see R12
   assert property ((sink_on & ~st_reg.group_sel) == 7'h00)
   else $error("group sink driven as independent");

   a_sink_clear_off: // see R15
   assert property ((reg_req.wr && reg_req.addr == `BLS_OFS_SINK_EN && !reg_req.wdata[0]) |=> !sink_on[0])
   else $error("sink still on after enable clear");

   a_active_entry: // see R23
   assert property ((st_reg.mode == bls_pkg::BLS_STANDBY && reg_req.wr && reg_req.addr == `BLS_OFS_MODE
      && reg_req.wdata[`BLS_MODE_ACT] && !st_reg.fs2.hot) |=> st_reg.mode == bls_pkg::BLS_ACTIVE)
   else $error("active request did not enter active mode");

   a_short_park: // see R17
   assert property ((st_reg.mode == bls_pkg::BLS_ACTIVE && st_reg.blank == 32'h0000_0000 && st_reg.fs2.shorted
      && !st_reg.fs2.hot && !(reg_req.wr && reg_req.addr == `BLS_OFS_MODE))
      |=> low_current && st_reg.flags[`BLS_FLAG_SHORT])
   else $error("short after blanking not parked");

   a_short_restart: // see R18
   assert property ((st_reg.mode == bls_pkg::BLS_SHORTED && reg_req.wr && reg_req.addr == `BLS_OFS_MODE
      && reg_req.wdata[`BLS_MODE_ACT] && !st_reg.fs2.hot) |=> !low_current && st_reg.blank == 32'(BLANK_CYC))
   else $error("rewrite of active request did not restart");

endmodule

/* File: bench/bls_host.sv */
// host model that drives register reads and writes into the sequencer
`timescale 1ns/1ps
module bls_host (
   // clock
   input wire logic sys_clk,
   // register access
   output bls_pkg::bls_reg_req_s reg_req,
   input wire logic [7:0] rd_data
);
   // ----------------------------------------------------------------
   // bus cycles
   // ----------------------------------------------------------------
   // bus idle from time zero
   initial reg_req = '0;

   // one-edge write strobe; released fields are inverted so stale values never look valid
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      #1;
      reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge sys_clk);
      #1;
      reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask

   // read data appears at the taking edge and is sampled one edge later
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      #1;
      reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge sys_clk);
      #1;
      reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
      @(posedge sys_clk);
      #1;
      d = rd_data;
   endtask
endmodule

/* File: bench/backlight_sequencer_fault_irq_bench.sv */
// self-checking bench for the backlight sequencer
`timescale 1ns/1ps
`include "bls_consts.svh"
module backlight_sequencer_fault_irq_bench;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   bls_pkg::bls_fault_s fault_in = '0;
   bls_pkg::bls_reg_req_s reg_req;
   logic [7:0] rd_data, v;
   logic [6:0] backlight_level, sink_on;
   logic charge_pump_en, low_current, irq_out_n;
   int mismatches = 0;
   int tests_run = 0;
   int cycles = 0;
   int hi, lo;
   localparam logic [7:0] MX = {1'b0, `BLS_MAX_CODE};
   localparam logic [7:0] DM = {1'b0, `BLS_DIM_CODE};
   localparam logic [7:0] MD = `BLS_OFS_MODE;
   localparam logic [7:0] FL = `BLS_OFS_FAULT;
   logic [7:0] offs [11] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h10, 8'h11, 8'h12, 8'h08};
   logic [7:0] on_exp [4] = '{8'd10, 8'd30, 8'd40, 8'd60};
   logic [1:0] off_code [4] = '{2'd1, 2'd2, 2'd3, 2'd1};
   logic [7:0] off_exp [4] = '{8'd30, 8'd60, 8'd90, 8'd30};

   // short counts so a second is 50 cycles and blanking is 20
   bls_sequencer #(.BLANK_CYC(20), .SUBTICK_CYC(10), .FADE_CYC(2)) i_bls_sequencer (
      .sys_clk(sys_clk), .srst(srst), .reg_req(reg_req), .rd_data(rd_data), .fault_in(fault_in),
      .backlight_level(backlight_level), .sink_on(sink_on), .charge_pump_en(charge_pump_en),
      .low_current(low_current), .irq_out_n(irq_out_n));
   bls_host i_bls_host (.sys_clk(sys_clk), .reg_req(reg_req), .rd_data(rd_data));

   // 250 MHz clock
   always #2 sys_clk = ~sys_clk;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task print_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // hang guard, far above the roughly 3000 cycles the tests need
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         $display("timeout after %0d cycles", cycles);
         print_verdict();
      end
   end

   task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value %s: expected %h seen %h", what, exp, got);
      end
   endtask

   task cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d);
      i_bls_host.wr(a, d);
   endtask

   task rchk(input logic [7:0] a, input logic [7:0] exp, input string what);
      i_bls_host.rd(a, v);
      chk(what, exp, v);
   endtask

   // skip the running on phase and the whole off phase after it, then time one full on and off pulse
   task measure(output int h, output int l);
      h = 0;
      l = 0;
      for (int n = 0; n < 300 && sink_on[0] !== 1'b0; n++) cyc(1);
      for (int n = 0; n < 300 && sink_on[0] !== 1'b1; n++) cyc(1);
      while (sink_on[0] === 1'b1 && h < 300) begin
         h++;
         cyc(1);
      end
      while (sink_on[0] === 1'b0 && l < 300) begin
         l++;
         cyc(1);
      end
   endtask

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      cyc(6);
      srst = 1'b0;
      cyc(1);
      // reset values, the last offset being unmapped
      foreach (offs[k]) rchk(offs[k], 8'h00, "reset reg");
      chk("irq reset", 8'h01, {7'h0, irq_out_n});
      wr(`BLS_OFS_CFG, 8'ha4);
      rchk(`BLS_OFS_CFG, 8'ha4, "cfg");
      $display("test reset done");

      // on, dim and off by host writes, fade bypass set
      wr(MD, 8'h01);
      wr(MD, 8'h21);
      cyc(3);
      chk("level max", MX, {1'b0, backlight_level});
      chk("pump on", 8'h01, {7'h0, charge_pump_en});
      wr(MD, 8'h31);
      cyc(300);
      chk("level dim", DM, {1'b0, backlight_level});
      wr(MD, 8'h21);
      cyc(300);
      chk("level undim", MX, {1'b0, backlight_level});
      wr(MD, 8'h01);
      cyc(3);
      chk("level off", 8'h00, {1'b0, backlight_level});
      $display("test host control done");

      // dim timer of two seconds expires between 50 and 100 cycles
      wr(`BLS_OFS_DIMD, 8'h02);
      wr(MD, 8'h21);
      cyc(40);
      rchk(MD, 8'h21, "dim early");
      cyc(70);
      rchk(MD, 8'h31, "dim set");
      cyc(200);
      chk("auto dim", DM, {1'b0, backlight_level});
      wr(MD, 8'h21);
      cyc(3);
      chk("redo max", MX, {1'b0, backlight_level});
      cyc(40);
      rchk(MD, 8'h21, "restart");
      cyc(70);
      rchk(MD, 8'h31, "dim again");
      wr(MD, 8'h01);
      wr(`BLS_OFS_DIMD, 8'h00);
      $display("test dim timer done");

      // off timer of three seconds expires between 100 and 150 cycles
      wr(`BLS_OFS_OFFD, 8'h03);
      wr(MD, 8'h21);
      cyc(90);
      rchk(MD, 8'h21, "off early");
      cyc(70);
      rchk(MD, 8'h01, "auto off");
      cyc(200);
      chk("off level", 8'h00, {1'b0, backlight_level});
      wr(`BLS_OFS_OFFD, 8'h00);
      $display("test off timer done");

      // overvoltage stops only the pump; flag masking and write-one clear
      wr(MD, 8'h21);
      cyc(3);
      fault_in.overvolt = 1'b1;
      cyc(5);
      chk("hv pump", 8'h00, {7'h0, charge_pump_en});
      chk("hv level", MX, {1'b0, backlight_level});
      fault_in.overvolt = 1'b0;
      cyc(5);
      chk("pump back", 8'h01, {7'h0, charge_pump_en});
      chk("irq masked", 8'h01, {7'h0, irq_out_n});
      rchk(FL, 8'h01, "hv flag");
      wr(`BLS_OFS_MASK, 8'h01);
      cyc(2);
      chk("irq on", 8'h00, {7'h0, irq_out_n});
      wr(FL, 8'h00);
      rchk(FL, 8'h01, "w0 keeps");
      wr(FL, 8'h01);
      rchk(FL, 8'h00, "w1 clears");
      chk("irq off", 8'h01, {7'h0, irq_out_n});
      fault_in.overvolt = 1'b1;
      cyc(1);
      fault_in.overvolt = 1'b0;
      cyc(5);
      rchk(FL, 8'h01, "hv again");
      wr(FL, 8'h01);
      $display("test overvoltage done");

      // thermal trip forces standby and re-flags while hot
      wr(`BLS_OFS_MASK, 8'h02);
      fault_in.hot = 1'b1;
      cyc(5);
      chk("hot level", 8'h00, {1'b0, backlight_level});
      chk("hot pump", 8'h00, {7'h0, charge_pump_en});
      chk("hot irq", 8'h00, {7'h0, irq_out_n});
      wr(FL, 8'h02);
      rchk(FL, 8'h02, "hot reflag");
      fault_in.hot = 1'b0;
      cyc(4);
      wr(FL, 8'h02);
      rchk(FL, 8'h00, "cool flag");
      wr(MD, 8'h21);
      cyc(3);
      chk("restart", MX, {1'b0, backlight_level});
      $display("test thermal done");

      // short ignored during blanking, then parks; rewrite of active restarts
      wr(`BLS_OFS_MASK, 8'h04);
      wr(MD, 8'h00);
      wr(MD, 8'h21);
      fault_in.shorted = 1'b1;
      cyc(8);
      chk("blanked", 8'h00, {7'h0, low_current});
      cyc(25);
      chk("parked", 8'h01, {7'h0, low_current});
      chk("park lvl", 8'h00, {1'b0, backlight_level});
      chk("short irq", 8'h00, {7'h0, irq_out_n});
      rchk(FL, 8'h04, "short flag");
      fault_in.shorted = 1'b0;
      wr(MD, 8'h21);
      cyc(3);
      chk("recover", 8'h00, {7'h0, low_current});
      wr(FL, 8'h04);
      $display("test short done");

      // without bypass, a re-enable mid-fade climbs from where the level stands
      wr(`BLS_OFS_CFG, 8'h00);
      wr(MD, 8'h31);
      cyc(10);
      wr(MD, 8'h21);
      cyc(2);
      chk("fade resume", 8'h01, {7'h0, backlight_level > DM[6:0] && backlight_level < MX[6:0]});
      cyc(300);
      chk("fade top", MX, {1'b0, backlight_level});
      $display("test fade resume done");

      // group sink ignores its enable; independent sink blinks
      wr(`BLS_OFS_SINK_EN, 8'h01);
      cyc(3);
      chk("group sink", 8'h00, {1'b0, sink_on});
      wr(`BLS_OFS_GROUP, 8'h01);
      cyc(3);
      chk("steady", 8'h01, {1'b0, sink_on});
      wr(`BLS_OFS_SINK_EN, 8'h00);
      for (int i = 0; i < 4; i++) begin
         wr(`BLS_OFS_BOFF_HI, {i[1:0], 6'h00});
         wr(`BLS_OFS_BOFF_LO, {6'h00, off_code[i]});
         wr(`BLS_OFS_SINK_EN, 8'h01);
         measure(hi, lo);
         chk("on time", on_exp[i], hi[7:0]);
         chk("off time", off_exp[i], lo[7:0]);
         wr(`BLS_OFS_SINK_EN, 8'h00);
         cyc(3);
         chk("sink off", 8'h00, {1'b0, sink_on});
         cyc(100);
         chk("stays off", 8'h00, {1'b0, sink_on});
      end
      $display("test blink done");
      print_verdict();
   end
endmodule
